// *** pkg/cab_pkg.sv ***
package cab_pkg;

   // Status register bit positions
   localparam int ST_C = 0;
   localparam int ST_Z = 1;
   localparam int ST_N = 2;
   localparam int ST_V = 3;
   localparam int ST_S = 4;
   localparam int ST_H = 5;
   localparam int ST_T = 6;
   localparam int ST_I = 7;

   // Values after reset
   localparam logic [7:0] STATUS_RST = 8'h00;
   localparam logic [15:0] PC_RST = 16'h0000;

   // Byte constants used by the arithmetic
   localparam logic [7:0] ALL_ONES = 8'hFF;
   localparam logic [7:0] ZERO_BYTE = 8'h00;
   localparam logic [7:0] SIGN_MAX = 8'h7F;
   localparam logic [7:0] SIGN_MIN = 8'h80;

   // Which status bits each instruction class updates
   localparam logic [7:0] UPD_ARITH = 8'h2F;
   localparam logic [7:0] UPD_LOGIC = 8'h0E;
   localparam logic [7:0] UPD_ONES = 8'h0F;
   localparam logic [7:0] UPD_WORD = 8'h1F;
   localparam logic [7:0] UPD_MUL = 8'h03;
   localparam logic [7:0] UPD_NONE = 8'h00;

   // Cycle counts
   localparam logic [2:0] CYC_ONE = 3'h1;
   localparam logic [2:0] CYC_WORD = 3'h2;
   localparam logic [2:0] CYC_MUL = 3'h2;
   localparam logic [2:0] CYC_REL_JUMP = 3'h2;
   localparam logic [2:0] CYC_PTR_JUMP = 3'h2;
   localparam logic [2:0] CYC_ABS_JUMP = 3'h3;
   localparam logic [2:0] CYC_REL_CALL = 3'h3;
   localparam logic [2:0] CYC_PTR_CALL = 3'h3;
   localparam logic [2:0] CYC_ABS_CALL = 3'h4;
   localparam logic [2:0] CYC_RETURN = 3'h4;
   localparam logic [2:0] CYC_TAKEN = 3'h2;
   localparam logic [2:0] CYC_SKIP_ONE = 3'h2;
   localparam logic [2:0] CYC_SKIP_TWO = 3'h3;

   // Program counter steps in words
   localparam int STEP_NEXT = 1;
   localparam int STEP_ABS_CALL = 2;
   localparam int STEP_SKIP_ONE = 2;
   localparam int STEP_SKIP_TWO = 3;

   typedef enum logic [5:0] {
      OP_ADD, OP_ADD_CARRY, OP_ADD_IMM_WORD, OP_SUB, OP_SUB_CONSTANT, OP_SUB_WITH_CARRY,
      OP_SUB_CONSTANT_WITH_CARRY, OP_SUB_IMM_WORD, OP_AND, OP_AND_CONSTANT, OP_OR, OP_OR_CONSTANT,
      OP_XOR_REGISTERS, OP_ONES_COMPLEMENT, OP_TWOS_COMPLEMENT, OP_SET_MASK_BITS, OP_CLEAR_MASK_BITS,
      OP_INC, OP_DEC, OP_TEST_ZERO_MINUS, OP_CLEAR_REG, OP_LOAD_ALL_ONES,
      OP_MULTIPLY, OP_MULTIPLY_SIGNED, OP_MULTIPLY_SIGNED_UNSIGNED,
      OP_FRAC_MULTIPLY_UNSIGNED, OP_FRAC_MULTIPLY_SIGNED, OP_FRAC_MULTIPLY_MIXED,
      OP_RELATIVE_JUMP, OP_POINTER_JUMP, OP_ABS_JUMP, OP_RELATIVE_SUBCALL, OP_POINTER_SUBCALL,
      OP_ABS_SUBCALL, OP_SUB_RETURN, OP_INTERRUPT_RETURN,
      OP_COMPARE_SKIP_EQUAL, OP_COMPARE, OP_COMPARE_WITH_CARRY, OP_COMPARE_IMMEDIATE,
      OP_SKIP_REG_BIT_CLEAR, OP_SKIP_REG_BIT_SET, OP_SKIP_IO_BIT_CLEAR, OP_SKIP_IO_BIT_SET,
      OP_BRANCH_STATUS_BIT_SET, OP_BRANCH_STATUS_BIT_CLEAR, OP_BRANCH_EQUAL, OP_BRANCH_NOT_EQUAL,
      OP_BRANCH_CARRY_SET, OP_BRANCH_CARRY_CLEAR, OP_BRANCH_SAME_OR_HIGHER, OP_BRANCH_LOWER,
      OP_BRANCH_MINUS, OP_BRANCH_PLUS, OP_BRANCH_SIGNED_GE, OP_BRANCH_SIGNED_LT,
      OP_BRANCH_HALFCARRY_SET, OP_BRANCH_HALFCARRY_CLEAR, OP_BRANCH_TFLAG_SET, OP_BRANCH_TFLAG_CLEAR
   } cab_op_t;

   // One decoded instruction from the fetch path
   typedef struct packed {
      cab_op_t op;
      logic [7:0] a;
      logic [7:0] b;
      logic [7:0] a_hi;
      logic [11:0] k_off;
      logic [2:0] bit_sel;
      logic [7:0] io_val;
      logic [15:0] target;
      logic [15:0] z_ptr;
      logic next_two_word;
   } cab_req_t;

   // Register file write towards the partner
   typedef struct packed {
      logic en;
      logic pair;
      logic prod;
      logic [7:0] lo;
      logic [7:0] hi;
   } cab_wr_t;

endpackage : cab_pkg

// *** testbench/cab_stack_model.sv ***
`timescale 1ns/10ps
module cab_stack_model
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // Stack traffic from the core
   input wire logic push_en_r,
   input wire logic [15:0] push_pc_r,
   input wire logic pop_en_r,
   output logic [15:0] stack_pc_i
);
   logic [15:0] mem [0:7];
   logic [2:0] sp_r;
   always_ff @(posedge core_clk)
   begin
      if (!rstn)
         sp_r <= 3'h0;
      else if (push_en_r)
      begin
         mem[sp_r] <= push_pc_r;
         sp_r <= sp_r + 3'h1;
      end
      else if (pop_en_r)
         sp_r <= sp_r - 3'h1;
   end
   // Empty stack shows junk, never a stale address
   assign stack_pc_i = (sp_r == 3'h0) ? 16'hA5A5 : mem[sp_r - 3'h1];
endmodule : cab_stack_model

// *** testbench/testbench.sv ***
`timescale 1ns/10ps
module testbench;
   logic core_clk;
   logic rstn;
   logic req_valid;
   logic req_ready;
   cab_pkg::cab_req_t req_i;
   cab_pkg::cab_wr_t wr_r;
   cab_pkg::cab_wr_t wv;
   logic [1:0] pv;
   logic [15:0] stack_pc_i;
   logic push_en_r;
   logic [15:0] push_pc_r;
   logic pop_en_r;
   logic [12:0] pc_r;
   logic [7:0] status_r;
   int err_count;
   int total_checks;
   cab_exec #(.PC_W(13)) cab_exec_i (.core_clk(core_clk), .rstn(rstn), .req_valid(req_valid),
      .req_ready(req_ready), .req_i(req_i), .wr_r(wr_r), .stack_pc_i(stack_pc_i), .push_en_r(push_en_r),
      .push_pc_r(push_pc_r), .pop_en_r(pop_en_r), .pc_r(pc_r), .status_r(status_r));
   cab_stack_model cab_stack_model_i (.core_clk(core_clk), .rstn(rstn), .push_en_r(push_en_r),
      .push_pc_r(push_pc_r), .pop_en_r(pop_en_r), .stack_pc_i(stack_pc_i));
   initial
   begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end
   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      total_checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("unexpected %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : tally_and_finish
   // Issue one instruction, hold it until taken, then count busy cycles and catch the write
   task automatic run(input cab_pkg::cab_op_t op, input logic [7:0] a, input logic [7:0] b,
      input logic [11:0] k, input logic nt, input logic [2:0] cyc, input logic [7:0] st, input logic [12:0] pc);
      logic ok;
      logic [2:0] n;
      ok = 1'b0;
      n = 3'h0;
      @(posedge core_clk);
      req_valid <= 1'b1;
      req_i <= '{op, a, b, 8'hFF, k, 3'h3, 8'h08, 16'h0100, 16'h0040, nt};
      while (!ok)
      begin
         @(negedge core_clk);
         ok = (req_ready === 1'b1);
         @(posedge core_clk);
      end
      req_valid <= 1'b0;
      wv = '0;
      pv = 2'b00;
      do
      begin
         @(negedge core_clk);
         n++;
         if (wr_r.en | wr_r.pair | wr_r.prod)
            wv = wr_r;
         if (push_en_r | pop_en_r)
            pv = {push_en_r, pop_en_r};
      end
      while (req_ready !== 1'b1 && n < 3'h6);
      chk("cycles", 16'(cyc), 16'(n));
      chk("status", 16'(st), 16'(status_r));
      chk("pc", 16'(pc), 16'(pc_r));
   endtask : run
   initial
   begin
      #100000;
      err_count++;
      tally_and_finish();
   end
   initial
   begin
      rstn = 1'b0;
      req_valid = 1'b0;
      req_i = '0;
      err_count = 0;
      total_checks = 0;
      repeat (3) @(posedge core_clk);
      rstn <= 1'b1;
      run(cab_pkg::OP_ADD, 8'h0F, 8'h01, 12'h000, 1'b0, 3'h1, 8'h20, 13'h0001);
      chk("sum", 16'h0010, {8'h00, wv.lo});
      run(cab_pkg::OP_SUB, 8'h00, 8'h01, 12'h000, 1'b0, 3'h1, 8'h25, 13'h0002);
      run(cab_pkg::OP_ADD_IMM_WORD, 8'hFF, 8'h01, 12'h000, 1'b0, 3'h2, 8'h23, 13'h0003);
      chk("word", 16'h0000, {wv.hi, wv.lo});
      run(cab_pkg::OP_MULTIPLY_SIGNED, 8'hFF, 8'h02, 12'h000, 1'b0, 3'h2, 8'h21, 13'h0004);
      chk("product", 16'hFFFE, {wv.hi, wv.lo});
      run(cab_pkg::OP_FRAC_MULTIPLY_UNSIGNED, 8'h80, 8'h80, 12'h000, 1'b0, 3'h2, 8'h20, 13'h0005);
      chk("frac", 16'h8000, {wv.hi, wv.lo});
      run(cab_pkg::OP_LOAD_ALL_ONES, 8'h12, 8'h00, 12'h000, 1'b0, 3'h1, 8'h20, 13'h0006);
      chk("all_ones", 16'h00FF, {8'h00, wv.lo});
      run(cab_pkg::OP_RELATIVE_JUMP, 8'h00, 8'h00, 12'hFFE, 1'b0, 3'h2, 8'h20, 13'h0005);
      run(cab_pkg::OP_ABS_SUBCALL, 8'h00, 8'h00, 12'h000, 1'b0, 3'h4, 8'h20, 13'h0100);
      chk("push", 16'h0007, push_pc_r);
      chk("stack", 16'h0002, 16'(pv));
      run(cab_pkg::OP_INTERRUPT_RETURN, 8'h00, 8'h00, 12'h000, 1'b0, 3'h4, 8'hA0, 13'h0007);
      chk("stack", 16'h0001, 16'(pv));
      run(cab_pkg::OP_COMPARE_SKIP_EQUAL, 8'h5A, 8'h5A, 12'h000, 1'b1, 3'h3, 8'hA0, 13'h000A);
      run(cab_pkg::OP_BRANCH_HALFCARRY_SET, 8'h00, 8'h00, 12'h005, 1'b0, 3'h2, 8'hA0, 13'h0010);
      run(cab_pkg::OP_COMPARE_IMMEDIATE, 8'h10, 8'h20, 12'h000, 1'b0, 3'h1, 8'h85, 13'h0011);
      run(cab_pkg::OP_XOR_REGISTERS, 8'h5A, 8'h5A, 12'h000, 1'b0, 3'h1, 8'h83, 13'h0012);
      chk("xor", 16'h0100, {7'h00, wv.en, wv.lo});
      run(cab_pkg::OP_ONES_COMPLEMENT, 8'h0F, 8'h00, 12'h000, 1'b0, 3'h1, 8'h85, 13'h0013);
      chk("ones_comp", 16'h00F0, {8'h00, wv.lo});
      run(cab_pkg::OP_BRANCH_SIGNED_GE, 8'h00, 8'h00, 12'h005, 1'b0, 3'h1, 8'h85, 13'h0014);
      run(cab_pkg::OP_INC, 8'h7F, 8'h00, 12'h000, 1'b0, 3'h1, 8'h8D, 13'h0015);
      chk("inc", 16'h0080, {8'h00, wv.lo});
      run(cab_pkg::OP_BRANCH_LOWER, 8'h00, 8'h00, 12'h005, 1'b0, 3'h2, 8'h8D, 13'h001B);
      run(cab_pkg::OP_BRANCH_STATUS_BIT_SET, 8'h00, 8'h00, 12'hFFC, 1'b0, 3'h2, 8'h8D, 13'h0018);
      run(cab_pkg::OP_SKIP_IO_BIT_SET, 8'h00, 8'h00, 12'h000, 1'b0, 3'h2, 8'h8D, 13'h001A);
      run(cab_pkg::OP_SKIP_REG_BIT_CLEAR, 8'h00, 8'h00, 12'h000, 1'b1, 3'h3, 8'h8D, 13'h001D);
      run(cab_pkg::OP_MULTIPLY, 8'hFF, 8'h02, 12'h000, 1'b0, 3'h2, 8'h8C, 13'h001E);
      chk("product", 16'h01FE, {wv.hi, wv.lo});
      tally_and_finish();
   end
endmodule : testbench

// *** verilog/cab_exec.sv ***
`timescale 1ns/10ps
// Contract
// - Add, add-carry: store sum, ZCNVH, one cycle
// - Subtracts: store difference, ZCNVH, one cycle
// - Word add/sub immediate: pair, ZCNVS, two cycles
// - And, or, xor: store, ZNV, one cycle
// - Ones complement ZCNV; twos complement adds H
// - Mask set/clear ZNV; all ones: no flags
// - Inc, dec, test, clear: only ZNV flags
// - Multiplies: product to pair zero, ZC, two cycles
// - Fractional multiplies shift product left one
// - Jumps: relative/pointer two cycles, absolute three
// - Calls: relative/pointer three cycles, absolute four
// - Compare-skip-equal skips next, one/two/three cycles
// - Compares: subtract, no store, ZNVCH, one cycle
// - Register bit skips, flags untouched, 1/2/3
// - I/O bit skips, PC plus one, two or three
// - Status bit branches: 1 untaken, 2 taken
// - Named branches test Z, C, N, H, T
// - Same-or-higher on C=0, lower on C=1
// - Signed ge on N^V=0, lt on N^V=1
module cab_exec
#(
   parameter int PC_W = 13
)
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // Instruction from the fetch path
   input wire logic req_valid,
   output logic req_ready,
   input wire cab_pkg::cab_req_t req_i,
   // Register file write
   output cab_pkg::cab_wr_t wr_r,
   // Stack
   input wire logic [15:0] stack_pc_i,
   output logic push_en_r,
   output logic [15:0] push_pc_r,
   output logic pop_en_r,
   // Core state
   output logic [PC_W-1:0] pc_r,
   output logic [7:0] status_r
);
   if (PC_W < 9 || PC_W > 16)
   begin : g_pc_w_check
      $error("cab_exec: PC_W must lie in 9..16");
   end

   function automatic logic [10:0] add8(input logic [7:0] x, input logic [7:0] y, input logic ci);
      logic [8:0] s;
      logic [4:0] n;
      s = {1'b0, x} + {1'b0, y} + {8'h00, ci};
      n = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, ci};
      return {n[4], (x[7] == y[7]) && (s[7] != x[7]), s[8], s[7:0]};
   endfunction : add8

   function automatic logic [10:0] sub8(input logic [7:0] x, input logic [7:0] y, input logic ci);
      logic [8:0] s;
      logic [4:0] n;
      s = {1'b0, x} - {1'b0, y} - {8'h00, ci};
      n = {1'b0, x[3:0]} - {1'b0, y[3:0]} - {4'h0, ci};
      return {n[4], (x[7] != y[7]) && (s[7] != x[7]), s[8], s[7:0]};
   endfunction : sub8

   logic issue;
   logic [2:0] cnt_r;
   logic mul_pend_r;
   logic [10:0] add_r;
   logic [10:0] sub_r;
   logic [10:0] neg_r;
   logic [16:0] wsum;
   logic chain_c;
   logic [7:0] res;
   logic h, v, c, n, z, taken, skip, word, mul_go;
   logic [7:0] upd;
   logic [7:0] st_nxt;
   logic [PC_W-1:0] pc_one;
   logic [PC_W-1:0] pc_rel;
   logic [PC_W-1:0] pc_nxt;
   logic [2:0] cyc_nxt;
   cab_pkg::cab_wr_t wr_nxt;
   logic push_nxt;
   logic pop_nxt;
   logic [15:0] ret_nxt;
   logic [15:0] mul_prod;
   logic mul_c, mul_z;
   logic sgn_x, sgn_y, frac;

   // One instruction at a time: the counter holds off the next one
   assign req_ready = (cnt_r == 3'h0);
   assign issue = req_valid && req_ready;

   assign pc_one = pc_r + PC_W'(cab_pkg::STEP_NEXT);
   assign pc_rel = pc_one + PC_W'($signed(req_i.k_off));
   assign chain_c = (req_i.op == cab_pkg::OP_ADD_CARRY) || (req_i.op == cab_pkg::OP_SUB_WITH_CARRY) ||
      (req_i.op == cab_pkg::OP_SUB_CONSTANT_WITH_CARRY) || (req_i.op == cab_pkg::OP_COMPARE_WITH_CARRY);
   assign add_r = add8(req_i.a, req_i.b, chain_c & status_r[cab_pkg::ST_C]);
   assign sub_r = sub8(req_i.a, req_i.b, chain_c & status_r[cab_pkg::ST_C]);
   assign neg_r = sub8(cab_pkg::ZERO_BYTE, req_i.a, 1'b0);

   // Branch condition on the current status bits
   always_comb
   begin
      case (req_i.op)
         cab_pkg::OP_BRANCH_STATUS_BIT_SET: taken = status_r[req_i.bit_sel];
         cab_pkg::OP_BRANCH_STATUS_BIT_CLEAR: taken = !status_r[req_i.bit_sel];
         cab_pkg::OP_BRANCH_EQUAL: taken = status_r[cab_pkg::ST_Z];
         cab_pkg::OP_BRANCH_NOT_EQUAL: taken = !status_r[cab_pkg::ST_Z];
         cab_pkg::OP_BRANCH_CARRY_SET: taken = status_r[cab_pkg::ST_C];
         cab_pkg::OP_BRANCH_CARRY_CLEAR: taken = !status_r[cab_pkg::ST_C];
         cab_pkg::OP_BRANCH_MINUS: taken = status_r[cab_pkg::ST_N];
         cab_pkg::OP_BRANCH_PLUS: taken = !status_r[cab_pkg::ST_N];
         cab_pkg::OP_BRANCH_HALFCARRY_SET: taken = status_r[cab_pkg::ST_H];
         cab_pkg::OP_BRANCH_HALFCARRY_CLEAR: taken = !status_r[cab_pkg::ST_H];
         cab_pkg::OP_BRANCH_TFLAG_SET: taken = status_r[cab_pkg::ST_T];
         cab_pkg::OP_BRANCH_TFLAG_CLEAR: taken = !status_r[cab_pkg::ST_T];
         cab_pkg::OP_BRANCH_SAME_OR_HIGHER: taken = !status_r[cab_pkg::ST_C];
         cab_pkg::OP_BRANCH_LOWER: taken = status_r[cab_pkg::ST_C];
         cab_pkg::OP_BRANCH_SIGNED_GE: taken = !(status_r[cab_pkg::ST_N] ^ status_r[cab_pkg::ST_V]);
         cab_pkg::OP_BRANCH_SIGNED_LT: taken = status_r[cab_pkg::ST_N] ^ status_r[cab_pkg::ST_V];
         default: taken = 1'b0;
      endcase
   end

   // Skip condition
   always_comb
   begin
      case (req_i.op)
         cab_pkg::OP_COMPARE_SKIP_EQUAL: skip = (req_i.a == req_i.b);
         cab_pkg::OP_SKIP_REG_BIT_CLEAR: skip = !req_i.a[req_i.bit_sel];
         cab_pkg::OP_SKIP_REG_BIT_SET: skip = req_i.a[req_i.bit_sel];
         cab_pkg::OP_SKIP_IO_BIT_CLEAR: skip = !req_i.io_val[req_i.bit_sel];
         cab_pkg::OP_SKIP_IO_BIT_SET: skip = req_i.io_val[req_i.bit_sel];
         default: skip = 1'b0;
      endcase
   end

   // Result, flags, next PC and cycle count of the offered instruction
   always_comb
   begin
      res = cab_pkg::ZERO_BYTE;
      {h, v, c} = 3'b000;
      upd = cab_pkg::UPD_NONE;
      word = 1'b0;
      wsum = 17'h00000;
      wr_nxt = '0;
      pc_nxt = pc_one;
      cyc_nxt = cab_pkg::CYC_ONE;
      push_nxt = 1'b0;
      pop_nxt = 1'b0;
      ret_nxt = 16'(pc_one);
      mul_go = 1'b0;
      case (req_i.op)
         cab_pkg::OP_ADD, cab_pkg::OP_ADD_CARRY:
            {h, v, c, res} = add_r;
         cab_pkg::OP_SUB, cab_pkg::OP_SUB_CONSTANT, cab_pkg::OP_SUB_WITH_CARRY,
         cab_pkg::OP_SUB_CONSTANT_WITH_CARRY, cab_pkg::OP_COMPARE, cab_pkg::OP_COMPARE_WITH_CARRY,
         cab_pkg::OP_COMPARE_IMMEDIATE:
            {h, v, c, res} = sub_r;
         cab_pkg::OP_AND, cab_pkg::OP_AND_CONSTANT: res = req_i.a & req_i.b;
         cab_pkg::OP_OR, cab_pkg::OP_OR_CONSTANT, cab_pkg::OP_SET_MASK_BITS: res = req_i.a | req_i.b;
         cab_pkg::OP_XOR_REGISTERS: res = req_i.a ^ req_i.b;
         cab_pkg::OP_CLEAR_MASK_BITS: res = req_i.a & (cab_pkg::ALL_ONES - req_i.b);
         cab_pkg::OP_LOAD_ALL_ONES: res = cab_pkg::ALL_ONES;
         cab_pkg::OP_ONES_COMPLEMENT: {c, res} = {1'b1, cab_pkg::ALL_ONES - req_i.a};
         cab_pkg::OP_TWOS_COMPLEMENT: {h, v, c, res} = neg_r;
         cab_pkg::OP_INC: {v, res} = {req_i.a == cab_pkg::SIGN_MAX, req_i.a + 8'h01};
         cab_pkg::OP_DEC: {v, res} = {req_i.a == cab_pkg::SIGN_MIN, req_i.a - 8'h01};
         cab_pkg::OP_TEST_ZERO_MINUS: res = req_i.a & req_i.a;
         cab_pkg::OP_CLEAR_REG: res = req_i.a ^ req_i.a;
         cab_pkg::OP_ADD_IMM_WORD:
         begin
            wsum = {1'b0, req_i.a_hi, req_i.a} + {11'h000, req_i.b[5:0]};
            v = !req_i.a_hi[7] && wsum[15];
            c = req_i.a_hi[7] && !wsum[15];
         end
         cab_pkg::OP_SUB_IMM_WORD:
         begin
            wsum = {1'b0, req_i.a_hi, req_i.a} - {11'h000, req_i.b[5:0]};
            v = req_i.a_hi[7] && !wsum[15];
            c = !req_i.a_hi[7] && wsum[15];
         end
         cab_pkg::OP_RELATIVE_JUMP: {pc_nxt, cyc_nxt} = {pc_rel, cab_pkg::CYC_REL_JUMP};
         cab_pkg::OP_POINTER_JUMP: {pc_nxt, cyc_nxt} = {req_i.z_ptr[PC_W-1:0], cab_pkg::CYC_PTR_JUMP};
         cab_pkg::OP_ABS_JUMP: {pc_nxt, cyc_nxt} = {req_i.target[PC_W-1:0], cab_pkg::CYC_ABS_JUMP};
         cab_pkg::OP_RELATIVE_SUBCALL: {push_nxt, pc_nxt, cyc_nxt} = {1'b1, pc_rel, cab_pkg::CYC_REL_CALL};
         cab_pkg::OP_POINTER_SUBCALL:
            {push_nxt, pc_nxt, cyc_nxt} = {1'b1, req_i.z_ptr[PC_W-1:0], cab_pkg::CYC_PTR_CALL};
         cab_pkg::OP_ABS_SUBCALL:
         begin
            {push_nxt, pc_nxt, cyc_nxt} = {1'b1, req_i.target[PC_W-1:0], cab_pkg::CYC_ABS_CALL};
            ret_nxt = 16'(pc_r + PC_W'(cab_pkg::STEP_ABS_CALL));
         end
         cab_pkg::OP_SUB_RETURN, cab_pkg::OP_INTERRUPT_RETURN:
            {pop_nxt, pc_nxt, cyc_nxt} = {1'b1, stack_pc_i[PC_W-1:0], cab_pkg::CYC_RETURN};
         // multiplier result arrives one cycle later
         cab_pkg::OP_MULTIPLY, cab_pkg::OP_MULTIPLY_SIGNED, cab_pkg::OP_MULTIPLY_SIGNED_UNSIGNED,
         cab_pkg::OP_FRAC_MULTIPLY_UNSIGNED, cab_pkg::OP_FRAC_MULTIPLY_SIGNED,
         cab_pkg::OP_FRAC_MULTIPLY_MIXED:
            {mul_go, cyc_nxt} = {1'b1, cab_pkg::CYC_MUL};
         default:
         begin
            // skip length follows the skipped instruction
            if (skip)
            begin
               pc_nxt = req_i.next_two_word ? pc_r + PC_W'(cab_pkg::STEP_SKIP_TWO)
                                            : pc_r + PC_W'(cab_pkg::STEP_SKIP_ONE);
               cyc_nxt = req_i.next_two_word ? cab_pkg::CYC_SKIP_TWO : cab_pkg::CYC_SKIP_ONE;
            end
            // taken branch costs one extra cycle
            else if (taken)
            begin
               pc_nxt = pc_rel;
               cyc_nxt = cab_pkg::CYC_TAKEN;
            end
         end
      endcase
      case (req_i.op)
         cab_pkg::OP_ADD, cab_pkg::OP_ADD_CARRY, cab_pkg::OP_SUB, cab_pkg::OP_SUB_CONSTANT,
         cab_pkg::OP_SUB_WITH_CARRY, cab_pkg::OP_SUB_CONSTANT_WITH_CARRY, cab_pkg::OP_TWOS_COMPLEMENT:
            {upd, wr_nxt.en} = {cab_pkg::UPD_ARITH, 1'b1};
         cab_pkg::OP_COMPARE, cab_pkg::OP_COMPARE_WITH_CARRY, cab_pkg::OP_COMPARE_IMMEDIATE:
            upd = cab_pkg::UPD_ARITH;
         cab_pkg::OP_AND, cab_pkg::OP_AND_CONSTANT, cab_pkg::OP_OR, cab_pkg::OP_OR_CONSTANT,
         cab_pkg::OP_XOR_REGISTERS, cab_pkg::OP_SET_MASK_BITS, cab_pkg::OP_CLEAR_MASK_BITS,
         cab_pkg::OP_INC, cab_pkg::OP_DEC, cab_pkg::OP_TEST_ZERO_MINUS, cab_pkg::OP_CLEAR_REG:
            {upd, wr_nxt.en} = {cab_pkg::UPD_LOGIC, 1'b1};
         cab_pkg::OP_ONES_COMPLEMENT: {upd, wr_nxt.en} = {cab_pkg::UPD_ONES, 1'b1};
         // all ones leaves the flags alone
         cab_pkg::OP_LOAD_ALL_ONES: wr_nxt.en = 1'b1;
         cab_pkg::OP_ADD_IMM_WORD, cab_pkg::OP_SUB_IMM_WORD:
         begin
            {upd, wr_nxt.pair, word, cyc_nxt} = {cab_pkg::UPD_WORD, 1'b1, 1'b1, cab_pkg::CYC_WORD};
            res = wsum[7:0];
         end
         default: upd = cab_pkg::UPD_NONE;
      endcase
      wr_nxt.lo = res;
      wr_nxt.hi = wsum[15:8];
      n = word ? wsum[15] : res[7];
      // Carry-chained subtracts only keep Z set across a zero result
      z = word ? (wsum[15:0] == 16'h0000) : (res == cab_pkg::ZERO_BYTE) &&
         (!(chain_c && req_i.op != cab_pkg::OP_ADD_CARRY) || status_r[cab_pkg::ST_Z]);
      st_nxt = status_r & ~upd;
      st_nxt = st_nxt | (upd & {2'b00, h, n ^ v, v, n, z, c});
   end

   assign sgn_x = (req_i.op == cab_pkg::OP_MULTIPLY_SIGNED) || (req_i.op == cab_pkg::OP_MULTIPLY_SIGNED_UNSIGNED) ||
      (req_i.op == cab_pkg::OP_FRAC_MULTIPLY_SIGNED) || (req_i.op == cab_pkg::OP_FRAC_MULTIPLY_MIXED);
   assign sgn_y = (req_i.op == cab_pkg::OP_MULTIPLY_SIGNED) || (req_i.op == cab_pkg::OP_FRAC_MULTIPLY_SIGNED);
   assign frac = (req_i.op == cab_pkg::OP_FRAC_MULTIPLY_UNSIGNED) ||
      (req_i.op == cab_pkg::OP_FRAC_MULTIPLY_SIGNED) || (req_i.op == cab_pkg::OP_FRAC_MULTIPLY_MIXED);

   cab_mult u_mult
   (
      .core_clk(core_clk),
      .rstn(rstn),
      .start(issue && mul_go),
      .x(req_i.a),
      .y(req_i.b),
      .sgn_x(sgn_x),
      .sgn_y(sgn_y),
      .frac(frac),
      .prod_r(mul_prod),
      .carry_r(mul_c),
      .zero_r(mul_z)
   );

   // Busy counter
   always_ff @(posedge core_clk)
   begin
      if (!rstn)
         cnt_r <= 3'h0;
      else if (issue)
         cnt_r <= cyc_nxt - 3'h1;
      else if (cnt_r != 3'h0)
         cnt_r <= cnt_r - 3'h1;
   end

   // Results, flags, stack traffic; a multiply writes back in its second cycle
   always_ff @(posedge core_clk)
   begin
      if (!rstn)
      begin
         mul_pend_r <= 1'b0;
         wr_r <= '0;
         status_r <= cab_pkg::STATUS_RST;
         push_en_r <= 1'b0;
         push_pc_r <= 16'h0000;
         pop_en_r <= 1'b0;
      end
      else
      begin
         mul_pend_r <= issue && mul_go;
         push_en_r <= issue && push_nxt;
         pop_en_r <= issue && pop_nxt;
         if (issue && push_nxt)
            push_pc_r <= ret_nxt;
         if (mul_pend_r)
         begin
            wr_r <= '{en: 1'b0, pair: 1'b0, prod: 1'b1, lo: mul_prod[7:0], hi: mul_prod[15:8]};
            status_r <= (status_r & ~cab_pkg::UPD_MUL) | {6'h00, mul_z, mul_c};
         end
         else if (issue)
         begin
            wr_r <= wr_nxt;
            status_r <= (req_i.op == cab_pkg::OP_INTERRUPT_RETURN) ? (st_nxt | 8'h80) : st_nxt;
         end
         else
            wr_r <= '0;
      end
   end

   // Program counter
   always_ff @(posedge core_clk)
   begin
      if (!rstn)
         pc_r <= cab_pkg::PC_RST[PC_W-1:0];
      else if (issue)
         pc_r <= pc_nxt;
   end

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rstn);

   a_add_result: assert property (issue && req_i.op == cab_pkg::OP_ADD |=>
      wr_r.en && wr_r.lo == 8'($past(req_i.a) + $past(req_i.b)) && req_ready)
      else $error("add result or timing wrong");
   a_sub_borrow: assert property (issue && req_i.op == cab_pkg::OP_SUB |=>
      status_r[cab_pkg::ST_C] == ($past(req_i.a) < $past(req_i.b)))
      else $error("subtract borrow wrong");
   a_word_timing: assert property (issue && req_i.op == cab_pkg::OP_ADD_IMM_WORD |=>
      wr_r.pair && !req_ready ##1 req_ready)
      else $error("word op not two cycles");
   a_logic_vclear: assert property (issue && req_i.op == cab_pkg::OP_XOR_REGISTERS |=>
      !status_r[cab_pkg::ST_V] && status_r[cab_pkg::ST_Z] == ($past(req_i.a) == $past(req_i.b)))
      else $error("xor flags wrong");
   a_ones_carry: assert property (issue && req_i.op == cab_pkg::OP_ONES_COMPLEMENT |=>
      status_r[cab_pkg::ST_C] && wr_r.lo == ~$past(req_i.a))
      else $error("ones complement wrong");
   a_allones_flags: assert property (issue && req_i.op == cab_pkg::OP_LOAD_ALL_ONES |=>
      status_r == $past(status_r) && wr_r.lo == cab_pkg::ALL_ONES)
      else $error("load all ones touched flags");
   a_inc_carry: assert property (issue && req_i.op == cab_pkg::OP_INC |=>
      status_r[cab_pkg::ST_C] == $past(status_r[cab_pkg::ST_C]))
      else $error("increment changed carry");
   a_mult_pair: assert property (issue && req_i.op == cab_pkg::OP_MULTIPLY |=>
      !wr_r.prod ##1 wr_r.prod && {wr_r.hi, wr_r.lo} == ({8'h00, $past(req_i.a, 2)} * {8'h00, $past(req_i.b, 2)}))
      else $error("multiply product wrong");
   a_rel_jump: assert property (issue && req_i.op == cab_pkg::OP_RELATIVE_JUMP |=>
      pc_r == $past(pc_rel) && !req_ready)
      else $error("relative jump wrong");
   a_skip_two: assert property (issue && skip && req_i.next_two_word |=>
      !req_ready [*2] ##1 req_ready)
      else $error("two word skip not three cycles");
   a_signed_ge: assert property (issue && req_i.op == cab_pkg::OP_BRANCH_SIGNED_GE &&
      (status_r[cab_pkg::ST_N] ^ status_r[cab_pkg::ST_V]) |=> pc_r == $past(pc_one) && req_ready)
      else $error("signed ge taken wrongly");

   c_mult_done: cover property (issue && mul_go ##2 wr_r.prod);
   c_branch_taken: cover property (issue && taken);
   c_skip_two: cover property (issue && skip && req_i.next_two_word);
endmodule : cab_exec

// *** verilog/cab_mult.sv ***
`timescale 1ns/10ps
module cab_mult
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // Operands
   input wire logic start,
   input wire logic [7:0] x,
   input wire logic [7:0] y,
   input wire logic sgn_x,
   input wire logic sgn_y,
   input wire logic frac,
   // Registered product
   output logic [15:0] prod_r,
   output logic carry_r,
   output logic zero_r
);
   logic signed [17:0] full;
   logic [15:0] shaped;

   assign full = $signed({sgn_x & x[7], x}) * $signed({sgn_y & y[7], y});
   // Carry is the product's top bit before the fractional shift
   assign shaped = frac ? {full[14:0], 1'b0} : full[15:0];

   always_ff @(posedge core_clk)
   begin
      if (!rstn)
      begin
         prod_r <= 16'h0000;
         carry_r <= 1'b0;
         zero_r <= 1'b0;
      end
      else if (start)
      begin
         prod_r <= shaped;
         carry_r <= full[15];
         zero_r <= (shaped == 16'h0000);
      end
   end
endmodule : cab_mult
